// >>> tfs_pkg.sv
/*
 * Package for the table fill and search unit: opcodes, widths, states.
 * Assumes a single synchronous clock domain and a word memory with a
 * one-cycle read latency.
 */
package tfs_pkg;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 16;
    localparam int ACC_W = 32;
    localparam int LEN_W = 8;
    localparam logic [LEN_W-1:0] LEN_MAX = 8'hff;
    localparam logic [ACC_W-1:0] ACC_MISS_VALUE = 32'h0000_0000;
    localparam logic [LEN_W-1:0] OFFSET_START = 8'h00;
    localparam logic [1:0] OP_FILL = 2'h0;
    localparam logic [1:0] OP_FIND_EQ = 2'h1;
    localparam logic [1:0] OP_FIND_ABOVE = 2'h2;
    localparam logic [1:0] OP_NONE = 2'h3;

    typedef enum logic [2:0] {
        TFS_IDLE = 3'h0,
        TFS_ISSUE = 3'h1,
        TFS_WAIT = 3'h3,
        TFS_DONE = 3'h2
    } tfs_state_type;
endpackage : tfs_pkg

// >>> tfs_table_unit.sv
/*
 * Table fill and search unit: fill a word table with one value, find the
 * first word equal to a value from an offset, or find the first word above
 * a value from the table start. Results go to the accumulator.
 * Assumes the sequencer presents parameters in the i_start cycle, when they are captured, and
 * that memory returns read data exactly one cycle after o_mem_rd.
 */
module tfs_table_unit (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Sequencer side
    input wire logic i_start,
    input wire logic [1:0] i_op,
    input wire logic [tfs_pkg::WORD_W-1:0] i_operand,
    input wire logic [tfs_pkg::ACC_W-1:0] i_acc,
    input wire logic [tfs_pkg::ACC_W-1:0] i_stack1,
    input wire logic [tfs_pkg::ACC_W-1:0] i_stack2,
    output logic o_busy,
    output logic o_done,
    output logic o_acc_we,
    output logic [tfs_pkg::ACC_W-1:0] o_acc,
    output logic o_search_miss_flag,
    // Word memory side
    output logic o_mem_wr,
    output logic o_mem_rd,
    output logic [tfs_pkg::ADDR_W-1:0] o_mem_addr,
    output logic [tfs_pkg::WORD_W-1:0] o_mem_wdata,
    input wire logic [tfs_pkg::WORD_W-1:0] i_mem_rdata
);
    tfs_pkg::tfs_state_type state_reg, state_next;
    logic [1:0] op_reg;
    logic [tfs_pkg::ADDR_W-1:0] base_reg;
    logic [tfs_pkg::LEN_W-1:0] len_reg;
    logic [tfs_pkg::LEN_W-1:0] idx_reg;
    logic [tfs_pkg::WORD_W-1:0] value_reg;
    logic hit_reg;
    logic [tfs_pkg::LEN_W-1:0] hit_idx_reg;
    logic rd_valid_reg;
    logic [tfs_pkg::LEN_W-1:0] rd_idx_reg;
    logic [tfs_pkg::LEN_W-1:0] cmp_idx_reg;
    logic busy_reg, done_reg, acc_we_reg, miss_reg;
    logic [tfs_pkg::ACC_W-1:0] acc_reg;
    logic mem_wr_reg, mem_rd_reg;
    logic [tfs_pkg::ADDR_W-1:0] mem_addr_reg;
    logic [tfs_pkg::WORD_W-1:0] mem_wdata_reg;

    // Parameter decode at start, from the stack levels the issuer loaded
    wire logic start_ok = i_start && (i_op != tfs_pkg::OP_NONE);
    wire logic is_eq = (i_op == tfs_pkg::OP_FIND_EQ);
    wire logic [tfs_pkg::LEN_W-1:0] start_len = is_eq ?
        i_stack2[tfs_pkg::LEN_W-1:0] : i_stack1[tfs_pkg::LEN_W-1:0];
    wire logic [tfs_pkg::ADDR_W-1:0] start_base = is_eq ?
        i_stack1[tfs_pkg::ADDR_W-1:0] : i_acc[tfs_pkg::ADDR_W-1:0];
    // Offset beyond 8 bits is always outside a table of at most 255 words
    wire logic offset_wide = (i_acc[tfs_pkg::ACC_W-1:tfs_pkg::LEN_W] != '0);
    wire logic [tfs_pkg::LEN_W-1:0] start_idx = is_eq ?
        i_acc[tfs_pkg::LEN_W-1:0] : tfs_pkg::OFFSET_START;
    wire logic bad_offset = is_eq && (offset_wide || (start_idx >= start_len));

    // Compare data read last cycle against the operand as unsigned words
    wire logic word_eq = (i_mem_rdata == value_reg);
    wire logic word_above = (i_mem_rdata > value_reg);
    wire logic word_hit = (op_reg == tfs_pkg::OP_FIND_EQ) ? word_eq : word_above;
    wire logic last_issue = (idx_reg == len_reg);
    wire logic [tfs_pkg::ADDR_W-1:0] cur_addr =
        base_reg + {{(tfs_pkg::ADDR_W-tfs_pkg::LEN_W){1'b0}}, idx_reg};

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            tfs_pkg::TFS_IDLE: begin
                if (start_ok) begin
                    state_next = tfs_pkg::TFS_ISSUE;
                end
            end
            tfs_pkg::TFS_ISSUE: begin
                if (last_issue || hit_reg) begin
                    state_next = (op_reg == tfs_pkg::OP_FILL) ?
                        tfs_pkg::TFS_DONE : tfs_pkg::TFS_WAIT;
                end
            end
            tfs_pkg::TFS_WAIT: begin
                state_next = tfs_pkg::TFS_DONE;
            end
            tfs_pkg::TFS_DONE: begin
                state_next = tfs_pkg::TFS_IDLE;
            end
            default: begin
                state_next = tfs_pkg::TFS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_reg <= tfs_pkg::TFS_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Operation parameters, captured once so the sequencer may move on
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            op_reg <= tfs_pkg::OP_NONE;
            base_reg <= '0;
            len_reg <= '0;
            value_reg <= '0;
        end else if (state_reg == tfs_pkg::TFS_IDLE && start_ok) begin
            op_reg <= i_op;
            base_reg <= start_base;
            len_reg <= start_len;
            value_reg <= i_operand;
        end
    end

    // Walk index; in ISSUE it addresses the next word, in WAIT it stands past the last word issued
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            idx_reg <= '0;
        end else if (state_reg == tfs_pkg::TFS_IDLE && start_ok) begin
            // A bad offset parks the index at the end, so no read is issued
            idx_reg <= bad_offset ? start_len : start_idx;
        end else if (state_reg == tfs_pkg::TFS_ISSUE && !last_issue && !hit_reg) begin
            idx_reg <= idx_reg + 8'h01;
        end
    end

    // A hit is seen one cycle after its read; the first one wins
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            hit_reg <= 1'b0;
            hit_idx_reg <= '0;
        end else if (state_reg == tfs_pkg::TFS_IDLE) begin
            hit_reg <= 1'b0;
        end else if (rd_valid_reg && !hit_reg && word_hit) begin
            hit_reg <= 1'b1;
            hit_idx_reg <= cmp_idx_reg;
        end
    end

    // Memory strobes: fill writes, searches read, one word per cycle
    wire logic issue_now = (state_reg == tfs_pkg::TFS_ISSUE) && !last_issue && !hit_reg
        && !(rd_valid_reg && word_hit);
    // Read data stands the cycle after the strobe, so its index trails by two
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rd_valid_reg <= 1'b0;
            rd_idx_reg <= '0;
            cmp_idx_reg <= '0;
        end else begin
            rd_valid_reg <= mem_rd_reg;
            rd_idx_reg <= issue_now ? idx_reg : rd_idx_reg;
            cmp_idx_reg <= rd_idx_reg;
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            mem_wr_reg <= 1'b0;
            mem_rd_reg <= 1'b0;
            mem_addr_reg <= '0;
            mem_wdata_reg <= '0;
        end else begin
            mem_wr_reg <= issue_now && (op_reg == tfs_pkg::OP_FILL);
            mem_rd_reg <= issue_now && (op_reg != tfs_pkg::OP_FILL);
            mem_addr_reg <= issue_now ? cur_addr : mem_addr_reg;
            mem_wdata_reg <= value_reg;
        end
    end

    // Completion and results, presented with a one-cycle done pulse
    wire logic finishing = (state_reg == tfs_pkg::TFS_DONE);
    wire logic found = hit_reg;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            acc_we_reg <= 1'b0;
            acc_reg <= '0;
            miss_reg <= 1'b0;
        end else begin
            busy_reg <= (state_next != tfs_pkg::TFS_IDLE);
            done_reg <= finishing;
            acc_we_reg <= finishing && (op_reg != tfs_pkg::OP_FILL);
            if (finishing && op_reg != tfs_pkg::OP_FILL) begin
                acc_reg <= found ? {{(tfs_pkg::ACC_W-tfs_pkg::LEN_W){1'b0}}, hit_idx_reg}
                    : tfs_pkg::ACC_MISS_VALUE;
                miss_reg <= !found;
            end
        end
    end

    assign o_busy = busy_reg;
    assign o_done = done_reg;
    assign o_acc_we = acc_we_reg;
    assign o_acc = acc_reg;
    assign o_search_miss_flag = miss_reg;
    assign o_mem_wr = mem_wr_reg;
    assign o_mem_rd = mem_rd_reg;
    assign o_mem_addr = mem_addr_reg;
    assign o_mem_wdata = mem_wdata_reg;
endmodule : tfs_table_unit

// >>> tfs_mem_model.sv
/* Word memory model facing the table unit.
   Assumes one clock; read data comes one cycle after the read strobe. */
module tfs_mem_model (
    // Clock and strobes
    input wire logic i_clk,
    input wire logic i_wr,
    input wire logic i_rd,
    // Address and data
    input wire logic [15:0] i_addr,
    input wire logic [15:0] i_wdata,
    output logic [15:0] o_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [256];
    initial o_rdata = 16'h0000;
    // Outside a read the bus toggles, so stale data never looks valid
    always @(posedge i_clk) begin
        if (i_wr) mem[i_addr[7:0]] <= i_wdata;
        o_rdata <= i_rd ? mem[i_addr[7:0]] : ~o_rdata;
    end
endmodule : tfs_mem_model

// >>> tfs_monitor.sv
/* Port checker for the table unit.
   Assumes the single clock i_clk with synchronous reset i_rst. */
module tfs_monitor (
    // Clock, reset, request
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_start,
    input wire logic [1:0] i_op,
    // Unit outputs
    input wire logic o_busy,
    input wire logic o_done,
    input wire logic o_acc_we,
    input wire logic [31:0] o_acc,
    input wire logic o_search_miss_flag,
    input wire logic o_mem_wr,
    input wire logic [15:0] o_mem_addr,
    input wire logic [15:0] o_mem_wdata
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire logic take = i_start && (i_op != 2'h3) && !o_busy && !o_done;
    a_start_gives_busy: assert property (take |=> o_busy)
        else $error("start not taken");
    a_busy_ends_done: assert property ($rose(o_busy) |-> ##[1:1000] o_done)
        else $error("operation hung");
    a_done_is_idle: assert property (o_done |-> !o_busy)
        else $error("busy during done");
    a_we_on_done: assert property (o_acc_we |-> o_done)
        else $error("result outside done");
    a_miss_gives_zero: assert property (
        o_acc_we && o_search_miss_flag |-> o_acc == 32'h0)
        else $error("miss result not zero");
    a_flag_holds: assert property ($changed(o_search_miss_flag) |-> o_acc_we)
        else $error("flag changed off completion");
    a_acc_holds: assert property ($changed(o_acc) |-> o_acc_we)
        else $error("result changed off completion");
    a_offset_width: assert property (o_acc_we |-> o_acc[31:8] == 24'h0)
        else $error("offset too wide");
    a_fill_steps: assert property (o_mem_wr && $past(o_mem_wr) |->
        o_mem_addr == $past(o_mem_addr) + 16'h1 && $stable(o_mem_wdata))
        else $error("fill address or value wrong");
    a_write_busy: assert property (o_mem_wr |-> o_busy)
        else $error("write while idle");
    cover property (o_acc_we && !o_search_miss_flag);
    cover property (o_acc_we && o_search_miss_flag);
    cover property (o_mem_wr ##1 o_mem_wr);
endmodule : tfs_monitor
bind tfs_table_unit tfs_monitor tfs_monitor_inst (.i_clk, .i_rst, .i_start, .i_op, .o_busy,
    .o_done, .o_acc_we, .o_acc, .o_search_miss_flag, .o_mem_wr, .o_mem_addr, .o_mem_wdata);

// >>> tb.sv
/* Self-checking bench for the table unit and its memory model.
   Assumes the unit samples parameters only at the start edge. */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'b0, i_rst = 1'b1, i_start = 1'b0;
    logic [1:0] i_op = 2'h3;
    logic [15:0] i_operand = 16'h0;
    logic [31:0] i_acc = 32'h0, i_stack1 = 32'h0, i_stack2 = 32'h0, o_acc;
    logic o_busy, o_done, o_acc_we, o_search_miss_flag, o_mem_wr, o_mem_rd;
    logic [15:0] o_mem_addr, o_mem_wdata, i_mem_rdata;
    logic [15:0] ref_m [256];
    int num_errors = 0, total_checks = 0, seed = 49, cycles = 0;
    always #2 i_clk = ~i_clk;
    tfs_table_unit tfs_table_unit_inst (.i_clk, .i_rst, .i_start, .i_op, .i_operand, .i_acc,
        .i_stack1, .i_stack2, .o_busy, .o_done, .o_acc_we, .o_acc, .o_search_miss_flag,
        .o_mem_wr, .o_mem_rd, .o_mem_addr, .o_mem_wdata, .i_mem_rdata);
    tfs_mem_model tfs_mem_model_inst (.i_clk, .i_wr(o_mem_wr), .i_rd(o_mem_rd),
        .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 100000) begin
            num_errors++;
            finish_test();
        end
    end
    task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] s);
        total_checks++;
        if (e !== s) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    function automatic logic [32:0] exp_find(input logic [1:0] op, input logic [15:0] v,
        input int st, input int off, input int len);
        for (int i = off; i < len; i++)
            if (op == 2'h1 ? ref_m[(st + i) % 256] == v : ref_m[(st + i) % 256] > v)
                return {1'b0, 32'(i)};
        return 33'h1_0000_0000;
    endfunction : exp_find
    // Parameters held until done, as the sequencer would
    task automatic go(input logic [1:0] op, input logic [15:0] v, input int a, s1, s2);
        int n = 0;
        {i_op, i_operand, i_acc, i_stack1, i_stack2} = {op, v, 32'(a), 32'(s1), 32'(s2)};
        i_start = 1'b1;
        @(posedge i_clk);
        #1 i_start = 1'b0;
        while (o_done !== 1'b1 && n < 2000) begin
            @(posedge i_clk);
            #1 n++;
        end
        chk("done", 33'h1, {32'h0, o_done});
    endtask : go
    initial begin
        logic [32:0] e;
        int st, len, off;
        logic [15:0] v;
        for (int i = 0; i < 256; i++) ref_m[i] = 16'(i);
        tfs_mem_model_inst.mem = ref_m;
        repeat (10) @(posedge i_clk);
        #1 i_rst = 1'b0;
        go(2'h0, 16'h1234, 4, 0, 0);
        v = 16'($random(seed));
        go(2'h0, v, 5, 255, 0);
        for (int i = 0; i < 255; i++) ref_m[(5 + i) % 256] = v;
        for (int i = 0; i < 256; i++)
            chk("word", {17'h0, ref_m[i]}, {17'h0, tfs_mem_model_inst.mem[i]});
        $display("fill test ended");
        for (int i = 0; i < 256; i++) ref_m[i] = 16'($random(seed) & 15);
        tfs_mem_model_inst.mem = ref_m;
        for (int k = 0; k < 40; k++) begin
            st = $random(seed) & 255;
            len = $random(seed) & 255;
            off = ($random(seed) & 255) % (len + 8);
            v = (k < 2) ? 16'hffff * k : 16'($random(seed) & 15);
            if (k % 2 == 0) begin
                go(2'h2, v, st, len, 0);
                e = exp_find(2'h2, v, st, 0, len);
            end else begin
                go(2'h1, v, off, st, len);
                e = exp_find(2'h1, v, st, off, len);
            end
            chk("result", e, {o_search_miss_flag, o_acc});
            chk("result write", 33'h1, {32'h0, o_acc_we});
        end
        $display("search test ended");
        go(2'h2, 16'hffff, 0, 255, 0);
        go(2'h0, 16'h0007, 9, 1, 0);
        chk("kept result", 33'h1_0000_0000, {o_search_miss_flag, o_acc});
        {i_op, i_start} = 3'b111;
        repeat (3) @(posedge i_clk);
        #1 chk("idle on op 3", 33'h0, {32'h0, o_busy});
        i_start = 1'b0;
        $display("hold test ended");
        finish_test();
    end
endmodule : tb
